// *** design/xor_unit_cfg.svh ***
// Constants for the unlink, exclusive-OR, zero-extend and table-write datapath
`ifndef XOR_UNIT_CFG_SVH
`define XOR_UNIT_CFG_SVH

// Opcode patterns, compared against the top bits of the instruction word; the short-literal mark is compared against bits 6:5
`define OPC_UNLINK 24'hfa8000
`define OPC_XOR_FILE 9'h16d
`define OPC_XOR_LONG_LIT 9'h165
`define OPC_XOR_BASE 5'h0d
`define OPC_ZERO_EXT 10'h3ee
`define OPC_TBL_WR_LO 9'h176
`define SHORT_LIT_MARK 2'h3

// Addressing mode codes of the p and q fields
`define MODE_DIRECT 3'h0
`define MODE_INDIRECT 3'h1
`define MODE_POST_DEC 3'h2
`define MODE_POST_INC 3'h3
`define MODE_PRE_DEC 3'h4
`define MODE_PRE_INC 3'h5

// Register indices and reset values
`define IDX_FIRST_WORK 4'h0
`define IDX_FRAME_PTR 4'he
`define IDX_STACK_PTR 4'hf
`define RST_STACK_PTR 16'h0800
`define STACK_STEP 16'h0002
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002

`endif

// *** design/xor_unit_pkg.sv ***
// Types shared by the exclusive-OR execution datapath
`include "xor_unit_cfg.svh"
package xor_unit_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] reg_idx_t;
   typedef enum logic [2:0]
   {
      AM_DIRECT = `MODE_DIRECT,
      AM_INDIRECT = `MODE_INDIRECT,
      AM_POST_DEC = `MODE_POST_DEC,
      AM_POST_INC = `MODE_POST_INC,
      AM_PRE_DEC = `MODE_PRE_DEC,
      AM_PRE_INC = `MODE_PRE_INC
   } addr_mode_e;
endpackage

// *** design/logic_unlink_extend_exec.sv ***
// Single-cycle datapath: frame unlink, exclusive-OR forms, zero-extend, table write low
`timescale 1ns/1ps
`default_nettype none
`include "xor_unit_cfg.svh"

module logic_unlink_extend_exec
(
   input wire logic clk, // 40 MHz core clock
   input wire logic resetn, // Synchronous reset, active low
   input wire logic instr_valid, // Instruction word is presented this cycle
   input wire logic [23:0] instr_word, // Decoded instruction word
   input wire logic [7:0] table_page_reg, // Upper address byte for table writes
   output logic [15:0] mem_raddr, // Data memory read byte address
   input wire xor_unit_pkg::word_t mem_rdata, // Word at the aligned read address
   output logic mem_we_ff, // Data memory write strobe
   output logic [15:0] mem_waddr_ff, // Data memory write byte address
   output xor_unit_pkg::word_t mem_wdata_ff, // Data memory write word
   output logic [1:0] mem_be_ff, // Data memory byte enables
   output logic latch_we_ff, // Program write latch strobe
   output logic [23:0] latch_addr_ff, // Program write latch byte address
   output xor_unit_pkg::word_t latch_data_ff, // Program write latch data
   output logic [1:0] latch_be_ff, // Program write latch byte enables
   output logic neg_ff, // Negative flag
   output logic zero_ff, // Zero flag
   output logic carry_ff, // Carry flag
   output logic exec_done_ff, // One-cycle pulse after an accepted instruction
   input wire xor_unit_pkg::reg_idx_t peek_sel, // Working register to read back
   output xor_unit_pkg::word_t peek_data_ff // Selected working register, one cycle late
);
   import xor_unit_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Address helpers, used for both source and destination operands

   function automatic word_t ea_calc(input logic [2:0] mode, input word_t rv, input logic bsz);
      word_t step;
      step = bsz ? `STEP_BYTE : `STEP_WORD;
      unique case (mode)
         `MODE_PRE_DEC: ea_calc = rv - step;
         `MODE_PRE_INC: ea_calc = rv + step;
         default: ea_calc = rv; // Offset modes are not handled; taken as plain indirect
      endcase
   endfunction

   function automatic word_t ptr_upd(input logic [2:0] mode, input word_t rv, input logic bsz);
      word_t step;
      step = bsz ? `STEP_BYTE : `STEP_WORD;
      unique case (mode)
         `MODE_POST_DEC, `MODE_PRE_DEC: ptr_upd = rv - step;
         `MODE_POST_INC, `MODE_PRE_INC: ptr_upd = rv + step;
         default: ptr_upd = rv;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Working registers and decode

   word_t wr_ff [16];
   word_t nxt_wr [16];

   wire logic is_unlink = instr_valid && (instr_word == `OPC_UNLINK);
   wire logic is_xf = instr_valid && (instr_word[23:15] == `OPC_XOR_FILE);
   wire logic is_xl = instr_valid && (instr_word[23:15] == `OPC_XOR_LONG_LIT);
   wire logic base_form = instr_valid && (instr_word[23:19] == `OPC_XOR_BASE);
   wire logic is_x5 = base_form && (instr_word[6:5] == `SHORT_LIT_MARK);
   wire logic is_xw = base_form && (instr_word[6:5] != `SHORT_LIT_MARK);
   wire logic is_zext = instr_valid && (instr_word[23:14] == `OPC_ZERO_EXT);
   wire logic is_tw = instr_valid && (instr_word[23:15] == `OPC_TBL_WR_LO);
   wire logic is_xor = is_xf || is_xl || is_x5 || is_xw;

   wire logic byte_op = instr_word[14];
   wire logic dest_file = instr_word[13];
   wire logic [12:0] file_addr = instr_word[12:0];
   wire logic [2:0] qm = instr_word[13:11];
   wire logic [2:0] pm = instr_word[6:4];
   wire reg_idx_t base_idx = instr_word[18:15];
   wire reg_idx_t d_idx = instr_word[10:7];
   wire reg_idx_t s_idx = instr_word[3:0];
   wire reg_idx_t lit_idx = instr_word[3:0];
   wire logic src_byte = byte_op || is_zext;

   ////////////////////////////////////////////////////////////////////////////////
   // Operand fetch; one read port serves the file, pop or indirect source

   wire word_t fp_val = wr_ff[`IDX_FRAME_PTR];
   wire word_t pop_addr = fp_val - `STACK_STEP;
   wire word_t src_ea = ea_calc(pm, wr_ff[s_idx], src_byte);
   wire word_t dst_ea = ea_calc(qm, wr_ff[d_idx], byte_op);
   wire logic src_direct = (pm == `MODE_DIRECT);
   wire logic dst_direct = (qm == `MODE_DIRECT);

   assign mem_raddr = is_unlink ? pop_addr : (is_xf ? {3'h0, file_addr} : src_ea);

   wire byte_t rd_byte = mem_raddr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
   wire word_t rd_val = byte_op ? {8'h00, rd_byte} : mem_rdata;
   wire word_t src_val = src_direct ? wr_ff[s_idx] : rd_val;
   wire byte_t ze_byte = src_direct ? wr_ff[s_idx][7:0] : rd_byte;

   // Operand pair per form; the default register is register zero for the file form
   wire word_t opa = is_xf ? wr_ff[`IDX_FIRST_WORK] :
                     (is_xl ? wr_ff[lit_idx] : wr_ff[base_idx]);
   wire word_t opb = is_xf ? rd_val :
                     (is_xl ? {6'h00, instr_word[13:4]} :
                     (is_x5 ? {11'h000, instr_word[4:0]} : src_val));
   wire word_t xor_res = opa ^ opb;
   wire word_t res = is_zext ? {8'h00, ze_byte} : xor_res;
   wire logic res_neg = byte_op && !is_zext ? res[7] : res[15];
   wire logic res_zero = byte_op && !is_zext ? (res[7:0] == 8'h00) : (res == 16'h0000);

   ////////////////////////////////////////////////////////////////////////////////
   // Next register file; later writes take priority over pointer updates

   function automatic word_t merge(input word_t old, input word_t val, input logic bsz);
      merge = bsz ? {old[15:8], val[7:0]} : val;
   endfunction

   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         nxt_wr[i] = wr_ff[i];
      end
      if (is_unlink)
      begin
         nxt_wr[`IDX_STACK_PTR] = pop_addr;
         nxt_wr[`IDX_FRAME_PTR] = mem_rdata;
      end
      if (is_xw || is_zext || is_tw)
      begin
         nxt_wr[s_idx] = ptr_upd(pm, wr_ff[s_idx], src_byte);
      end
      if ((is_x5 || is_xw || is_tw) && !dst_direct)
      begin
         nxt_wr[d_idx] = ptr_upd(qm, wr_ff[d_idx], byte_op);
      end
      if (is_xf && !dest_file)
      begin
         nxt_wr[`IDX_FIRST_WORK] = merge(nxt_wr[`IDX_FIRST_WORK], res, byte_op);
      end
      if (is_xl)
      begin
         nxt_wr[lit_idx] = merge(nxt_wr[lit_idx], res, byte_op);
      end
      if ((is_x5 || is_xw) && dst_direct)
      begin
         nxt_wr[d_idx] = merge(nxt_wr[d_idx], res, byte_op);
      end
      if (is_zext)
      begin
         nxt_wr[d_idx] = res;
      end
   end

   // Register file storage; stack pointer has its own reset value
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (!resetn)
            wr_ff[i] <= (i == 15) ? `RST_STACK_PTR : 16'h0000;
         else
            wr_ff[i] <= nxt_wr[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory and latch write selection; byte data is copied into both lanes

   wire logic nxt_mem_we = (is_xf && dest_file) || ((is_x5 || is_xw) && !dst_direct);
   wire word_t nxt_mem_waddr = is_xf ? {3'h0, file_addr} : dst_ea;
   wire word_t nxt_mem_wdata = byte_op ? {res[7:0], res[7:0]} : res;
   wire logic [1:0] nxt_mem_be = byte_op ? (nxt_mem_waddr[0] ? 2'h2 : 2'h1) : 2'h3;
   wire word_t nxt_latch_data = byte_op ? {src_val[7:0], src_val[7:0]} : src_val;
   wire logic [1:0] nxt_latch_be = byte_op ? (dst_ea[0] ? 2'h2 : 2'h1) : 2'h3;

   // Writes land one cycle late; a read of the same word in that cycle sees old data
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         mem_we_ff <= 1'b0;
         mem_waddr_ff <= 16'h0000;
         mem_wdata_ff <= 16'h0000;
         mem_be_ff <= 2'h0;
         latch_we_ff <= 1'b0;
         latch_addr_ff <= 24'h000000;
         latch_data_ff <= 16'h0000;
         latch_be_ff <= 2'h0;
      end
      else
      begin
         mem_we_ff <= nxt_mem_we;
         mem_waddr_ff <= nxt_mem_waddr;
         mem_wdata_ff <= nxt_mem_wdata;
         mem_be_ff <= nxt_mem_be;
         latch_we_ff <= is_tw;
         latch_addr_ff <= {table_page_reg, dst_ea};
         latch_data_ff <= nxt_latch_data;
         latch_be_ff <= nxt_latch_be;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags; unlink and table write leave them alone

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         neg_ff <= 1'b0;
         zero_ff <= 1'b0;
         carry_ff <= 1'b0;
         exec_done_ff <= 1'b0;
         peek_data_ff <= 16'h0000;
      end
      else
      begin
         if (is_xor || is_zext)
         begin
            neg_ff <= res_neg;
            zero_ff <= res_zero;
         end
         if (is_zext)
            carry_ff <= 1'b1;
         exec_done_ff <= is_unlink || is_xor || is_zext || is_tw;
         peek_data_ff <= wr_ff[peek_sel];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_unlink_sp_pop: assert property (is_unlink |=>
      wr_ff[15] == $past(wr_ff[14]) - 16'h0002 && wr_ff[14] == $past(mem_rdata))
      else $error("unlink pointer restore wrong");
   a_unlink_flags_kept: assert property (is_unlink |=> $stable({neg_ff, zero_ff, carry_ff})
      && exec_done_ff) else $error("unlink changed flags");
   a_file_to_work: assert property (is_xf && !dest_file && !byte_op |=>
      wr_ff[0] == ($past(wr_ff[0]) ^ $past(mem_rdata)) && !mem_we_ff)
      else $error("file xor to work register wrong");
   a_file_to_mem: assert property (is_xf && dest_file |=> mem_we_ff &&
      mem_waddr_ff == {3'h0, $past(instr_word[12:0])}) else $error("file xor write-back wrong");
   a_lit_word: assert property (is_xl && !byte_op |=> wr_ff[$past(instr_word[3:0])] ==
      ($past(wr_ff[instr_word[3:0]]) ^ {6'h00, $past(instr_word[13:4])}))
      else $error("literal xor wrong");
   a_byte_keeps_high: assert property (is_xl && byte_op |=>
      wr_ff[$past(instr_word[3:0])][15:8] == $past(wr_ff[instr_word[3:0]][15:8]))
      else $error("byte xor touched high byte");
   a_flag_width: assert property (is_xl && byte_op |=>
      neg_ff == wr_ff[$past(instr_word[3:0])][7] && carry_ff == $past(carry_ff))
      else $error("byte xor flags wrong");
   a_short_lit: assert property (is_x5 && dst_direct && !byte_op && instr_word[10:7] !=
      instr_word[18:15] |=> wr_ff[$past(instr_word[10:7])] ==
      ($past(wr_ff[instr_word[18:15]]) ^ {11'h000, $past(instr_word[4:0])}))
      else $error("short literal xor wrong");
   a_src_post_inc: assert property (is_xw && pm == `MODE_POST_INC && !byte_op &&
      s_idx != d_idx |=> wr_ff[$past(s_idx)] == $past(wr_ff[s_idx]) + 16'h0002)
      else $error("source post-increment wrong");
   a_zext_result: assert property (is_zext |=> wr_ff[$past(d_idx)][15:8] == 8'h00 &&
      carry_ff && !neg_ff) else $error("zero-extend wrong");
   a_table_latch: assert property (is_tw |=> latch_we_ff && !mem_we_ff &&
      latch_addr_ff[23:16] == $past(table_page_reg)) else $error("table latch write wrong");
   a_table_lane: assert property (is_tw && byte_op |=>
      latch_be_ff == ($past(dst_ea[0]) ? 2'h2 : 2'h1)) else $error("table byte lane wrong");

   c_unlink: cover property (is_unlink);
   c_xor_indirect: cover property (is_xw && !dst_direct && byte_op);
   c_zext_mem: cover property (is_zext && !src_direct);
   c_table_byte_hi: cover property (is_tw && byte_op && dst_ea[0]);

endmodule // logic_unlink_extend_exec

`default_nettype wire

// *** dv/data_mem_model.sv ***
// Data memory model on the far side of the execution datapath
`timescale 1ns/1ps
`default_nettype none

module data_mem_model
(
   input wire logic clk, // Core clock
   input wire logic [15:0] raddr, // Byte read address
   output xor_unit_pkg::word_t rdata, // Word at the aligned address
   input wire logic we, // Write strobe
   input wire logic [15:0] waddr, // Byte write address
   input wire xor_unit_pkg::word_t wdata, // Write word
   input wire logic [1:0] be // Byte enables
);
   import xor_unit_pkg::*;
   word_t mem [0:32767];
   ////////////////////////////////////////////////////////////////////////////////
   // Known filler so no read ever returns an unknown word
   initial
   begin
      for (int i = 0; i < 32768; i++)
         mem[i] = 16'(i) ^ 16'ha5c3;
   end
   // Same-cycle read, as the datapath samples it at the executing edge
   assign rdata = mem[raddr[15:1]];
   // Lanes land separately, so a byte write never disturbs its neighbour
   always @(posedge clk)
   begin
      if (we && be[0])
         mem[waddr[15:1]][7:0] <= wdata[7:0];
      if (we && be[1])
         mem[waddr[15:1]][15:8] <= wdata[15:8];
   end
endmodule // data_mem_model
`default_nettype wire

// *** dv/logic_unlink_extend_exec_bench.sv ***
// Self-checking bench for the unlink, exclusive-OR, zero-extend and table-write datapath
`timescale 1ns/1ps
`default_nettype none

module logic_unlink_extend_exec_bench;
   import xor_unit_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   logic [23:0] instr_word = 24'h000000;
   logic [7:0] table_page_reg = 8'h00;
   reg_idx_t peek_sel = 4'h0;
   logic [15:0] mem_raddr, mem_waddr_ff, ea;
   word_t mem_rdata, mem_wdata_ff, latch_data_ff, peek_data_ff, src, r;
   logic mem_we_ff, latch_we_ff, neg_ff, zero_ff, carry_ff, exec_done_ff;
   logic [1:0] mem_be_ff, latch_be_ff;
   logic [23:0] latch_addr_ff;
   word_t pa [6] = '{16'h0200, 16'h0200, 16'h01fe, 16'h0202, 16'h01fe, 16'h0202};
   int fail_count = 0;
   int n_checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   always #12.5 clk = ~clk;
   logic_unlink_extend_exec i_dut
   (
      .clk, .resetn, .instr_valid, .instr_word, .table_page_reg, .mem_raddr,
      .mem_rdata, .mem_we_ff, .mem_waddr_ff, .mem_wdata_ff, .mem_be_ff, .latch_we_ff,
      .latch_addr_ff, .latch_data_ff, .latch_be_ff, .neg_ff, .zero_ff, .carry_ff,
      .exec_done_ff, .peek_sel, .peek_data_ff
   );
   data_mem_model i_mem
   (
      .clk, .raddr(mem_raddr), .rdata(mem_rdata), .we(mem_we_ff),
      .waddr(mem_waddr_ff), .wdata(mem_wdata_ff), .be(mem_be_ff)
   );
   ////////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and access tasks
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (fail_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Returns one ns after the executing edge, inside the cycle the strobes stand
   task automatic exec(input logic [23:0] w);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask
   task automatic run(input logic [23:0] w, input logic [2:0] f);
      exec(w);
      chk({exec_done_ff, neg_ff, zero_ff, carry_ff}, {1'b1, f});
   endtask
   // Register read-back is one cycle behind the selection; checked two cycles after it
   task automatic peek(input reg_idx_t n, input word_t exp);
      @(posedge clk);
      peek_sel <= n;
      repeat (2) @(posedge clk);
      #1;
      chk(peek_data_ff, exp);
   endtask
   // Loads a register by folding in a scratch word through the pointer in reg 13
   task automatic set_reg(input reg_idx_t n, input word_t v);
      @(posedge clk);
      peek_sel <= n;
      repeat (2) @(posedge clk);
      #1;
      i_mem.mem[16'h0080] = peek_data_ff ^ v;
      exec({5'h0d, n, 1'b0, 3'h0, n, 3'h1, 4'hd});
   endtask
   function automatic logic [23:0] wx(input logic [3:0] w, input logic b,
      input logic [2:0] q, input logic [3:0] d, input logic [2:0] p, input logic [3:0] s);
      return {5'h0d, w, b, q, d, p, s};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      peek(4'hf, 16'h0800);
      run({9'h165, 1'b0, 10'h100, 4'hd}, 3'b000);
      set_reg(4, 16'h6134);
      run({9'h165, 1'b0, 10'h108, 4'h4}, 3'b000);
      peek(4, 16'h603c);
      set_reg(0, 16'h7804);
      run({9'h165, 1'b1, 10'h023, 4'h0}, 3'b000);
      peek(0, 16'h7827);
      i_mem.mem[16'h0fff] = 16'h9439;
      run({9'h16d, 1'b1, 1'b1, 13'h1fff}, 3'b100);
      chk({mem_we_ff, mem_be_ff, mem_waddr_ff, mem_wdata_ff[15:8]}, {3'b110, 24'h1fffb3});
      peek(0, 16'h7827);
      chk(i_mem.mem[16'h0fff], 16'hb339);
      set_reg(0, 16'h6234);
      i_mem.mem[16'h0502] = 16'ha053;
      run({9'h16d, 1'b0, 1'b0, 13'h0a04}, 3'b100);
      chk(mem_we_ff, 1'b0);
      peek(0, 16'hc267);
      i_mem.mem[16'h0502] = 16'hc267;
      run({9'h16d, 1'b0, 1'b0, 13'h0a04}, 3'b010);
      set_reg(4, 16'hc822);
      run(wx(4, 0, 0, 5, 3'b111, 4'h6), 3'b100);
      peek(5, 16'hc834);
      set_reg(2, 16'h8505);
      set_reg(8, 16'h1004);
      run(wx(2, 1, 3, 8, 3'b111, 4'hf), 3'b000);
      chk({mem_we_ff, mem_be_ff, mem_waddr_ff, mem_wdata_ff[7:0]}, {3'b101, 24'h10041a});
      peek(8, 16'h1005);
      set_reg(1, 16'haaaa);
      set_reg(5, 16'h2000);
      set_reg(9, 16'h2600);
      i_mem.mem[16'h1000] = 16'h115a;
      run(wx(1, 1, 3, 9, 3, 5), 3'b100);
      chk({mem_we_ff, mem_be_ff, mem_waddr_ff, mem_wdata_ff[7:0]}, {3'b101, 24'h2600f0});
      peek(5, 16'h2001);
      set_reg(1, 16'hfedc);
      set_reg(5, 16'h1234);
      run(wx(1, 0, 0, 9, 0, 5), 3'b100);
      peek(9, 16'hece8);
      set_reg(1, 16'h0f0f);
      i_mem.mem[16'h00ff] = 16'h1234;
      i_mem.mem[16'h0100] = 16'h5678;
      i_mem.mem[16'h0101] = 16'h9abc;
      for (int m = 0; m < 6; m++)
      begin
         set_reg(6, 16'h0200);
         ea = (m == 4) ? 16'h01fe : (m == 5) ? 16'h0202 : 16'h0200;
         src = (m == 0) ? 16'h0200 : i_mem.mem[ea[15:1]];
         r = 16'h0f0f ^ src;
         run(wx(1, 0, 0, 9, m[2:0], 6), {r[15], r == 16'h0000, 1'b0});
         peek(9, r);
         peek(6, pa[m]);
      end
      set_reg(3, 16'h7839);
      run({10'h3ee, 3'h0, 4'h4, 3'h0, 4'h3}, 3'b001);
      peek(4, 16'h0039);
      run({9'h165, 1'b0, 10'h039, 4'h4}, 3'b011);
      set_reg(14, 16'h3006);
      set_reg(15, 16'h5000);
      i_mem.mem[16'h1802] = 16'h4abc;
      run(24'hfa8000, 3'b001);
      peek(15, 16'h3004);
      peek(14, 16'h4abc);
      set_reg(0, 16'h6628);
      set_reg(1, 16'h1225);
      run({9'h176, 1'b1, 3'h3, 4'h1, 3'h0, 4'h0}, 3'b001);
      chk({latch_we_ff, latch_be_ff, latch_addr_ff, latch_data_ff[15:8], mem_we_ff},
         {3'b110, 24'h001225, 8'h28, 1'b0});
      peek(1, 16'h1226);
      set_reg(6, 16'h1600);
      set_reg(8, 16'h7208);
      i_mem.mem[16'h0b00] = 16'h0130;
      @(posedge clk);
      table_page_reg <= 8'h01;
      run({9'h176, 1'b0, 3'h1, 4'h8, 3'h1, 4'h6}, 3'b001);
      chk({latch_we_ff, latch_be_ff, latch_addr_ff, latch_data_ff},
         {3'b111, 24'h017208, 16'h0130});
      exec(24'h000000);
      chk(exec_done_ff, 1'b0);
      complete_run();
   end
endmodule // logic_unlink_extend_exec_bench
`default_nettype wire
